// ===== core/gpio_pkg.sv
// Shared constants for the general purpose I/O port
package gpio_pkg;

  // Port geometry
  localparam int NUM_PINS = 8; // Pins of one port
  localparam int NUM_VECT = 7; // External interrupt vectors
  localparam int ADDR_W = 3; // Register address width
  localparam int DATA_W = 8; // Register data width

  // Register offsets
  localparam logic [2:0] ADDR_VALUE = 3'h0; // port_pin_value
  localparam logic [2:0] ADDR_DIR = 3'h1; // port_pin_direction
  localparam logic [2:0] ADDR_OPT = 3'h2; // port_pin_option
  localparam logic [2:0] ADDR_EDGE = 3'h3; // ext_irq_edge_control
  localparam logic [2:0] ADDR_PEND = 3'h4; // Pending requests, read only

  // Reset values
  localparam logic [7:0] RST_VALUE = 8'hFF; // Output latch
  localparam logic [7:0] RST_DIR = 8'h00; // All pins input
  localparam logic [7:0] RST_OPT = 8'h00; // Floating, no interrupt
  localparam logic [6:0] RST_EDGE = 7'h00; // All vectors falling edge
  localparam logic [6:0] RST_SRC = 7'h7F; // Idle level of vector sources
  localparam logic [7:0] RST_ZERO8 = 8'h00; // Cleared byte
  localparam logic [6:0] RST_ZERO7 = 7'h00; // Cleared vector set

  // Edge select field: one bit per vector, 0 falling, 1 rising
  localparam logic EDGE_FALL = 1'b0;
  localparam logic EDGE_RISE = 1'b1;

  // Pins that may act as interrupt inputs
  localparam logic [7:0] IRQ_CAPABLE = 8'hFF;

  // Pins tied to each vector; pins 6 and 7 share the last vector
  localparam logic [6:0][7:0] VEC_PIN_MASK = {
    8'hC0, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01
  };

endpackage : gpio_pkg

// ===== core/gpio_irq_if.sv
// Bundle between the port core and its interrupt edge unit
interface gpio_irq_if;
  logic [6:0] src; // Combined level per vector
  logic [6:0] rise_sel; // Edge select per vector
  logic [6:0] clear; // Clear pulse per vector
  logic [6:0] fire; // Qualifying edge seen this cycle
  logic [6:0] pending; // Request latches

  // Port core side
  modport core (
    output src,
    output rise_sel,
    output clear,
    input fire,
    input pending
  );

  // Edge unit side
  modport edge_side (
    input src,
    input rise_sel,
    input clear,
    output fire,
    output pending
  );
endinterface : gpio_irq_if

// ===== core/gpio_irq_edge.sv
// Edge detectors and request latches for the external interrupt vectors
module gpio_irq_edge (
  input wire logic clk,
  input wire logic reset_n,
  gpio_irq_if.edge_side irq
);

  logic [6:0] prev_src; // Source level one cycle ago
  logic [6:0] rise_edge; // Low to high seen
  logic [6:0] fall_edge; // High to low seen
  logic [6:0] next_pending;

  // Each vector picks its own edge independently
  assign rise_edge = irq.src & ~prev_src;
  assign fall_edge = ~irq.src & prev_src;
  assign irq.fire = (rise_edge & irq.rise_sel)
    | (fall_edge & ~irq.rise_sel);

  // A new edge wins over a clear in the same cycle
  assign next_pending = irq.fire | (irq.pending & ~irq.clear);

  // Previous level, idle high so reset makes no edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_src <= gpio_pkg::RST_SRC;
    end else begin
      prev_src <= irq.src;
    end
  end

  // Request latches
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq.pending <= gpio_pkg::RST_ZERO7;
    end else begin
      irq.pending <= next_pending;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Rising edge on vector 0 while rising is selected
  sequence s_rise0;
    !irq.src[0] ##1 (irq.src[0] && irq.rise_sel[0]);
  endsequence

  // Falling edge on vector 0 while falling is selected
  sequence s_fall0;
    irq.src[0] ##1 (!irq.src[0] && !irq.rise_sel[0]);
  endsequence

  chk_edge_sel_rise: assert property (
    s_rise0 |=> irq.pending[0])
    else $error("rising edge on vector 0 not latched");

  chk_edge_sel_fall: assert property (
    s_fall0 |=> irq.pending[0])
    else $error("falling edge on vector 0 not latched");

  chk_ack_clear: assert property (
    (irq.clear[0] && !irq.fire[0]) |=> !irq.pending[0])
    else $error("vector 0 request survived its clear");

endmodule // gpio_irq_edge

// ===== core/gpio_port.sv
// General purpose I/O port: registers, pin drivers, external interrupts
// Function
// - Input pin reads back its pin level
// - Writes to input pin touch latch only
// - Output pin drives its latch value
// - Output pin reads back the latch
// - Option bit selects floating or pull-up input
// - Option bit selects push-pull or open-drain output
// - Latch zero drives low; one high or released
// - Eight pins, bit x controls pin x
// - Option on input enables interrupt input
// - Each vector has own edge sensitivity
// - Seven vectors, pins may share one
// - Shared pins combine; low pin masks others
// - Vector fetch clears its pending request
// - Changing edge sensitivity clears all pending
// - Peripheral output overrides direction and option
// - Peripheral-driven pin reads back pin state
// - Direction/option pairs encode four pin modes
// - Request reaches CPU only when unmasked
module gpio_port (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WR_DATA,
  input wire logic WR_EN,
  input wire logic RD_EN,
  output logic [7:0] RD_DATA,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE,
  output logic [7:0] PIN_PULLUP,
  input wire logic [7:0] ALT_OE,
  input wire logic [7:0] ALT_OUT,
  output logic [7:0] ALT_IN,
  input wire logic [6:0] IRQ_ACK,
  input wire logic CPU_IMASK,
  output logic [6:0] IRQ_REQ
);

  // Software visible state
  logic [7:0] data_latch; // Output latch, port_pin_value
  logic [7:0] dir; // port_pin_direction, 1 = output
  logic [7:0] option; // port_pin_option
  logic [6:0] edge_ctl; // ext_irq_edge_control

  // Pin synchroniser; only the second stage is read
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;

  // Register decode
  logic sel_value;
  logic sel_dir;
  logic sel_opt;
  logic sel_edge;
  logic sel_pend;
  logic wr_value;
  logic wr_dir;
  logic wr_opt;
  logic wr_edge;
  logic edge_change; // Write that alters the sensitivity

  // Pin mode terms
  logic [7:0] out_mode; // Pins driven from the latch
  logic [7:0] irq_en; // Pins acting as interrupt inputs
  logic [7:0] read_value; // What a data read returns
  logic [7:0] next_oe;
  logic [7:0] next_out;
  logic [7:0] next_pullup;
  logic [7:0] next_rd_data;
  logic [6:0] next_irq_req;

  // Edge unit bundle
  gpio_irq_if irq ();

  // Address decode, one strobe per register
  assign sel_value = (ADDR == gpio_pkg::ADDR_VALUE);
  assign sel_dir = (ADDR == gpio_pkg::ADDR_DIR);
  assign sel_opt = (ADDR == gpio_pkg::ADDR_OPT);
  assign sel_edge = (ADDR == gpio_pkg::ADDR_EDGE);
  assign sel_pend = (ADDR == gpio_pkg::ADDR_PEND);
  assign wr_value = WR_EN && sel_value;
  assign wr_dir = WR_EN && sel_dir;
  assign wr_opt = WR_EN && sel_opt;
  assign wr_edge = WR_EN && sel_edge;

  // Only a real change of sensitivity flushes requests
  assign edge_change = wr_edge && (WR_DATA[6:0] != edge_ctl);

  // Peripheral output takes the pin out of latch-driven output mode
  assign out_mode = dir & ~ALT_OE;

  // Limitation: arming a pin that is already low makes a falling edge
  // on its vector; arm with the pin high, or flush by a write that changes
  // the sensitivity afterwards
  // Interrupt input: input mode with option set
  // Outputs and plain inputs are excluded here
  assign irq_en = ~dir & ~ALT_OE & option & gpio_pkg::IRQ_CAPABLE;

  // Latch for own outputs, pin level otherwise
  assign read_value = (data_latch & out_mode) | (pin_sync & ~out_mode);

  // Enable: peripheral, push-pull, or open-drain pulling low
  assign next_oe = ALT_OE | (out_mode & (option | ~data_latch));

  // Level: open-drain only ever drives low
  assign next_out = (ALT_OE & ALT_OUT) | (out_mode & option & data_latch);

  // Pull-up only for inputs with option set
  assign next_pullup = ~dir & ~ALT_OE & option;

  // Read multiplexer; unmapped addresses answer zero
  assign next_rd_data = sel_value ? read_value :
    sel_dir ? dir :
    sel_opt ? option :
    sel_edge ? {1'b0, edge_ctl} :
    sel_pend ? {1'b0, irq.pending} :
    gpio_pkg::RST_ZERO8;

  // Request is passed on only while the CPU mask is clear
  assign next_irq_req = CPU_IMASK ? gpio_pkg::RST_ZERO7 : irq.pending;

  // Combine the enabled pins of each vector by AND
  // A disabled pin reads as high so it cannot make an edge
  genvar v;
  generate
    for (v = 0; v < gpio_pkg::NUM_VECT; v++) begin : g_vec
      assign irq.src[v] =
        &(pin_sync | ~(irq_en & gpio_pkg::VEC_PIN_MASK[v]));
    end
  endgenerate

  // Edge select straight from the control register
  assign irq.rise_sel = edge_ctl;

  // Fetch clears one vector, a sensitivity change clears all
  assign irq.clear = IRQ_ACK | {7{edge_change}};

  // Edge detectors and request latches
  gpio_irq_edge u_edge (
    .clk (CLK),
    .reset_n (RESET_N),
    .irq (irq.edge_side)
  );

  // Two-stage synchroniser for asynchronous pin levels
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pin_meta <= gpio_pkg::RST_ZERO8;
      pin_sync <= gpio_pkg::RST_ZERO8;
    end else begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  // Output latch; written in any mode, pin follows only as output
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      data_latch <= gpio_pkg::RST_VALUE;
    end else if (wr_value) begin
      data_latch <= WR_DATA;
    end
  end

  // Direction register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dir <= gpio_pkg::RST_DIR;
    end else if (wr_dir) begin
      dir <= WR_DATA;
    end
  end

  // Option register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      option <= gpio_pkg::RST_OPT;
    end else if (wr_opt) begin
      option <= WR_DATA;
    end
  end

  // Edge sensitivity register
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      edge_ctl <= gpio_pkg::RST_EDGE;
    end else if (wr_edge) begin
      edge_ctl <= WR_DATA[6:0];
    end
  end

  // Pin drivers, registered so pins never glitch on decode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PIN_OE <= gpio_pkg::RST_ZERO8;
      PIN_OUT <= gpio_pkg::RST_ZERO8;
      PIN_PULLUP <= gpio_pkg::RST_ZERO8;
    end else begin
      PIN_OE <= next_oe;
      PIN_OUT <= next_out;
      PIN_PULLUP <= next_pullup;
    end
  end

  // Pin level towards the peripherals
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ALT_IN <= gpio_pkg::RST_ZERO8;
    end else begin
      ALT_IN <= pin_sync;
    end
  end

  // Read data stands one cycle, zero otherwise
  // Returning zero between reads keeps a stale answer from being
  // mistaken for a fresh one
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= gpio_pkg::RST_ZERO8;
    end else if (RD_EN) begin
      RD_DATA <= next_rd_data;
    end else begin
      RD_DATA <= gpio_pkg::RST_ZERO8;
    end
  end

  // Requests towards the interrupt controller
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ_REQ <= gpio_pkg::RST_ZERO7;
    end else begin
      IRQ_REQ <= next_irq_req;
    end
  end

  // Checks on the design's outputs and its internal interrupt signals
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Data read while pins are inputs
  chk_input_read: assert property (
    (RD_EN && sel_value) |=>
      ((RD_DATA ^ $past(pin_sync)) & ~$past(out_mode)) == 8'h00)
    else $error("input pin read does not show pin level");

  // Data read while pins are own outputs
  chk_latch_read: assert property (
    (RD_EN && sel_value) |=>
      ((RD_DATA ^ $past(data_latch)) & $past(out_mode)) == 8'h00)
    else $error("output pin read does not show latch");

  // Pins under a peripheral read back their level
  chk_alt_read: assert property (
    (RD_EN && sel_value && ALT_OE != 8'h00) |=>
      ((RD_DATA ^ $past(pin_sync)) & $past(ALT_OE)) == 8'h00)
    else $error("peripheral pin read does not show pin level");

  // Input pins stay released, even after a data write
  chk_input_hiz: assert property (
    (wr_value && dir == 8'h00 && ALT_OE == 8'h00) |=>
      PIN_OE == 8'h00)
    else $error("input pin driven after data write");

  // Push-pull outputs drive the latch both ways
  chk_pushpull_drive: assert property (
    1'b1 |=> ((PIN_OE ^ 8'hFF) & $past(out_mode & option)) == 8'h00
      && ((PIN_OUT ^ $past(data_latch)) & $past(out_mode & option))
      == 8'h00)
    else $error("push-pull pin not driving its latch");

  // Open-drain outputs release on one and pull low on zero
  chk_open_drain: assert property (
    1'b1 |=> ((PIN_OE ^ ~$past(data_latch)) & $past(out_mode & ~option))
      == 8'h00 && (PIN_OUT & $past(out_mode & ~option)) == 8'h00)
    else $error("open-drain pin drives high or fails low");

  // Pull-up follows option only in input mode
  chk_pullup_mode: assert property (
    1'b1 |=> PIN_PULLUP == $past(~dir & ~ALT_OE & option))
    else $error("pull-up does not match input option");

  // Peripheral output wins over port settings
  chk_alt_override: assert property (
    1'b1 |=> (($past(ALT_OE) & ~PIN_OE) == 8'h00)
      && (((PIN_OUT ^ $past(ALT_OUT)) & $past(ALT_OE)) == 8'h00))
    else $error("peripheral output not forced onto pin");

  // Sensitivity change leaves only fresh edges pending
  chk_edge_flush: assert property (
    edge_change |=> (irq.pending & ~$past(irq.fire)) == 7'h00)
    else $error("pending request survived sensitivity change");

  // No edge on any vector while the port has no interrupt pins
  chk_no_spurious: assert property (
    (irq_en == 8'h00) ##1 (irq_en == 8'h00) |-> irq.fire == 7'h00)
    else $error("request without any interrupt input");

  // CPU mask holds back every request
  chk_req_masked: assert property (
    CPU_IMASK |=> IRQ_REQ == 7'h00)
    else $error("request passed while CPU mask set");

  // Unmasked pending requests reach the CPU next cycle
  chk_req_passed: assert property (
    !CPU_IMASK |=> IRQ_REQ == $past(irq.pending))
    else $error("pending request not passed to CPU");

  // Pin 0 high, then low, while armed as a falling-edge input
  sequence s_pin0_fall;
    (irq_en[0] && !edge_ctl[0] && pin_sync[0])
      ##1 (irq_en[0] && !edge_ctl[0] && !pin_sync[0]);
  endsequence

  // Option bit on an input pin turns its edges into requests
  chk_irq_input: assert property (
    s_pin0_fall |=> irq.pending[0])
    else $error("falling edge on armed pin 0 not latched");

  // Pin 1 high, then low, while its vector watches falling edges
  sequence s_pin1_fall;
    (irq_en[1] && !edge_ctl[1] && pin_sync[1])
      ##1 (irq_en[1] && !edge_ctl[1] && !pin_sync[1]);
  endsequence

  // Vector 1 keeps its own sensitivity whatever vector 0 selects
  chk_vec1_fall: assert property (
    s_pin1_fall |=> irq.pending[1])
    else $error("falling edge on vector 1 not latched");

  // A fetch clears its vector unless a new edge arrives with it
  chk_fetch_clear: assert property (
    1'b1 |=> (irq.pending & $past(IRQ_ACK & ~irq.fire)) == 7'h00)
    else $error("fetched vector still pending");

  // One low pin holds the shared vector source low
  chk_low_masks: assert property (
    ((irq_en[7:6] & ~pin_sync[7:6]) != 2'b00) |-> !irq.src[6])
    else $error("low shared pin failed to mask vector");

endmodule // gpio_port

// ===== tb/gpio_pin_model.sv
// External circuitry model resolving the levels on the port pins
module gpio_pin_model (
  input wire logic clk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup,
  input wire logic [7:0] ext_oe,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_level
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] float_val = 8'h5A; // Level seen on undriven lines

  // Undriven lines flip every cycle, so a stale level is never trusted
  always_ff @(posedge clk) begin
    float_val <= ~float_val;
  end

  // Per line: device first, then outside source, then pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) begin // Device drives the line
        pin_level[i] = pin_out[i];
      end else if (ext_oe[i]) begin // Outside source drives it
        pin_level[i] = ext_val[i];
      end else if (pin_pullup[i]) begin // Pull-up holds it high
        pin_level[i] = 1'b1;
      end else begin // Floating, also a released open drain
        pin_level[i] = float_val[i];
      end
    end
  end
endmodule // gpio_pin_model

// ===== tb/test_gpio_port.sv
// Self-checking bench for the general purpose I/O port
module test_gpio_port;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0; // System clock
  logic reset_n = 1'b0; // Active low reset
  logic [2:0] addr = 3'h0; // Register address
  logic [7:0] wr_data = 8'h00; // Write data
  logic wr_en = 1'b0; // Write strobe
  logic rd_en = 1'b0; // Read strobe
  logic [7:0] rd_data; // Read data
  logic [7:0] pin_level; // Resolved pin levels
  logic [7:0] pin_out; // Device drive level
  logic [7:0] pin_oe; // Device drive enable
  logic [7:0] pin_pullup; // Device pull-up enable
  logic [7:0] alt_in; // Pin level to peripherals
  logic [7:0] alt_oe = 8'h00; // Peripheral output enable
  logic [7:0] alt_out = 8'h00; // Peripheral output level
  logic [7:0] ext_oe = 8'h00; // Outside source enable
  logic [7:0] ext_val = 8'h00; // Outside source level
  logic [6:0] irq_ack = 7'h00; // Vector fetch pulses
  logic cpu_imask = 1'b0; // Global interrupt mask
  logic [6:0] irq_req; // Requests to the processor
  logic [7:0] rv; // Last value read
  int mismatches = 0; // Failed comparisons
  int n_compared = 0; // All comparisons
  // Expected drive enable and pull-up per mode, latch 3C
  logic [7:0] exp_oe [4] = '{8'h00, 8'h00, 8'hC3, 8'hFF};
  logic [7:0] exp_pu [4] = '{8'h00, 8'hFF, 8'h00, 8'h00};

  // 100 MHz clock
  always #5 clk = ~clk;

  gpio_port u_gpio_port (
    .CLK(clk), .RESET_N(reset_n), .ADDR(addr), .WR_DATA(wr_data),
    .WR_EN(wr_en), .RD_EN(rd_en), .RD_DATA(rd_data),
    .PIN_IN(pin_level), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_PULLUP(pin_pullup), .ALT_OE(alt_oe), .ALT_OUT(alt_out),
    .ALT_IN(alt_in), .IRQ_ACK(irq_ack), .CPU_IMASK(cpu_imask),
    .IRQ_REQ(irq_req)
  );

  gpio_pin_model u_gpio_pin_model (
    .clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_oe(ext_oe), .ext_val(ext_val),
    .pin_level(pin_level)
  );

  // Let n edges pass, then step off the edge
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe
  task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // One-cycle read strobe; data stand only in the following cycle
  task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Outside circuitry changes the lines just after an edge
  task automatic set_pins(input logic [7:0] oe, input logic [7:0] v);
    @(posedge clk);
    ext_oe <= oe;
    ext_val <= v;
  endtask

  // One-cycle vector fetch
  task automatic fetch(input logic [6:0] v);
    @(posedge clk);
    irq_ack <= v;
    @(posedge clk);
    irq_ack <= 7'h00;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h",
               $time, what, seen, exp);
    end
  endtask

  task automatic rd_check(input logic [2:0] a, input logic [7:0] exp,
                          input string what);
    reg_read(a, rv);
    check(rv, exp, what);
  endtask

  task automatic end_test(input string name);
    $display("Test %s finished", name);
  endtask

  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Run limit against a hang
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    print_verdict();
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    cycles(1);
    check(pin_oe, 8'h00, "drive at reset");
    check({1'b0, irq_req}, 8'h00, "requests at reset");
    rd_check(gpio_pkg::ADDR_DIR, 8'h00, "direction reset");
    rd_check(gpio_pkg::ADDR_OPT, 8'h00, "option reset");
    rd_check(gpio_pkg::ADDR_EDGE, 8'h00, "edge reset");
    reg_write(3'h6, 8'hFF);
    rd_check(3'h6, 8'h00, "unmapped place");
    end_test("reset");

    // Input pins read the lines, latch writes stay inside
    set_pins(8'hFF, 8'hA5);
    reg_write(gpio_pkg::ADDR_VALUE, 8'h0F); // Whole byte
    cycles(4);
    check(pin_oe, 8'h00, "input not driven");
    rd_check(gpio_pkg::ADDR_VALUE, 8'hA5, "input reads pin");
    reg_write(gpio_pkg::ADDR_DIR, 8'hFF);
    rd_check(gpio_pkg::ADDR_VALUE, 8'h0F, "latch kept write");
    end_test("input");

    // All four direction and option pairs
    set_pins(8'h00, 8'h00);
    reg_write(gpio_pkg::ADDR_VALUE, 8'h3C);
    for (int m = 0; m < 4; m++) begin
      reg_write(gpio_pkg::ADDR_DIR, m[1] ? 8'hFF : 8'h00);
      reg_write(gpio_pkg::ADDR_OPT, m[0] ? 8'hFF : 8'h00);
      cycles(3);
      check(pin_oe, exp_oe[m], "mode drive");
      check(pin_out & pin_oe, 8'h3C & exp_oe[m], "mode level");
      check(pin_pullup, exp_pu[m], "mode pull-up");
      if (m > 1) begin
        rd_check(gpio_pkg::ADDR_VALUE, 8'h3C, "output latch");
      end
    end
    end_test("modes");

    // Peripheral takes pin 0 of a floating input port
    reg_write(gpio_pkg::ADDR_DIR, 8'h00);
    reg_write(gpio_pkg::ADDR_OPT, 8'h00);
    set_pins(8'hFE, 8'hA4);
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      alt_oe <= 8'h01;
      alt_out <= 8'(v);
      cycles(5);
      check(pin_oe, 8'h01, "peripheral owns pin");
      check(alt_in, 8'hA4 | 8'(v), "peripheral input");
      rd_check(gpio_pkg::ADDR_VALUE, 8'hA4 | 8'(v), "pin read");
    end
    @(posedge clk);
    alt_oe <= 8'h00;
    end_test("alternate");

    // Interrupt inputs, sensitivity, masking and clearing
    set_pins(8'hFF, 8'hFF);
    reg_write(gpio_pkg::ADDR_OPT, 8'h03);
    cycles(5);
    reg_write(gpio_pkg::ADDR_EDGE, 8'h01); // Vector 0 rising
    cycles(5);
    rd_check(gpio_pkg::ADDR_PEND, 8'h00, "no stray request");
    set_pins(8'hFF, 8'hFC);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h02, "vector 1 fall");
    set_pins(8'hFF, 8'hFD);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h03, "vector 0 rise");
    check({1'b0, irq_req}, 8'h03, "requests out");
    @(posedge clk);
    cpu_imask <= 1'b1;
    cycles(3);
    check({1'b0, irq_req}, 8'h00, "requests masked");
    @(posedge clk);
    cpu_imask <= 1'b0;
    fetch(7'h02);
    cycles(3);
    rd_check(gpio_pkg::ADDR_PEND, 8'h01, "fetch clears");
    reg_write(gpio_pkg::ADDR_EDGE, 8'h01); // Same value keeps requests
    rd_check(gpio_pkg::ADDR_PEND, 8'h01, "same edge kept");
    reg_write(gpio_pkg::ADDR_EDGE, 8'h00);
    cycles(2);
    rd_check(gpio_pkg::ADDR_PEND, 8'h00, "edge change clears");
    set_pins(8'hFF, 8'hF9);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h00, "plain input silent");
    set_pins(8'hFF, 8'hF8);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h01, "vector 0 fall");
    fetch(7'h01);
    end_test("interrupt");

    // Pins 6 and 7 share the last vector
    reg_write(gpio_pkg::ADDR_OPT, 8'hC3);
    set_pins(8'hFF, 8'h79);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h40, "shared vector");
    fetch(7'h40);
    set_pins(8'hFF, 8'h39);
    cycles(6);
    rd_check(gpio_pkg::ADDR_PEND, 8'h00, "low pin masks");
    end_test("shared");
    print_verdict();
  end
endmodule // test_gpio_port
